// ===== logic/cis_defines.svh
// Register offsets, bit positions and timing constants of the interrupt sequencer.
`ifndef CIS_DEFINES_SVH
`define CIS_DEFINES_SVH
`define CIS_OFS_CTRL 12'h000
`define CIS_OFS_PIE 12'h004
`define CIS_OFS_PIR 12'h008
`define CIS_OFS_CHG 12'h00c
`define CIS_OFS_EDGE 12'h010
`define CIS_OFS_SH_ACC 12'hf80
`define CIS_OFS_SH_STAT 12'hf84
`define CIS_OFS_SH_BANK 12'hf88
`define CIS_OFS_SH_IPTR 12'hf8c
`define CIS_OFS_SH_PCL 12'hf90
`define CIS_B_GLOBAL_EN 7
`define CIS_B_GROUP_EN 6
`define CIS_B_TIE 5
`define CIS_B_EIE 4
`define CIS_B_CIE 3
`define CIS_B_TIF 2
`define CIS_B_EIF 1
`define CIS_B_CIF 0
`define CIS_VECTOR 15'h0004
`define CIS_PC_RESET 15'h0000
`define CIS_Q1 2'h0
`define CIS_Q4 2'h3
`define CIS_PHASE_STEP 2'h1
`define CIS_ARM_DONE 2'h3
`define CIS_GUARD_WAKE 2'h2
`define CIS_STAT_SAVE_MASK 8'he7
`define CIS_RESP_OK 2'h0
`define CIS_RESP_ERR 2'h2
`endif

// ===== logic/cis_pkg.sv
// Shared types of the interrupt sequencer: saved core context and sequencer states.
package cis_pkg;
  // Core registers that are copied on entry and restored on return.
  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] status;
    logic [4:0] bank;
    logic [15:0] ind_ptr;
    logic [6:0] pc_high_latch;
  } cis_ctx_s;
  // Entry sequencer, one state per instruction cycle of the entry.
  typedef enum logic [1:0] {ST_IDLE, ST_FLUSH, ST_PUSH, ST_VECTOR} cis_state_e;
endpackage

// ===== logic/cis_sequencer.sv
// Interrupt flag, enable, vectoring and context shadow logic with an AXI4-Lite register port.
// Behaviour
// RL1: Any reset leaves all interrupts disabled.
// RL2: Take only with global and own enables.
// RL3: Flags set regardless of any enable.
// RL4: Entry flushes, clears enable, pushes, saves, vectors.
// RL5: Handler events flag but never redirect.
// RL6: Return pops, restores context, sets global enable.
// RL7: Pending enabled event serviced when enable returns.
// RL8: Handler software clears flags before returning.
// RL9: Synchronous latency three or four cycles.
// RL10: Asynchronous latency three to five cycles.
// RL11: Latency independent of instruction length.
// RL12: Pin flag sampled every first quarter.
// RL13: Software arms enables before sleeping.
// RL14: Wake vectors only when global enable set.
// RL15: Instruction after sleep runs before vectoring.
// RL16: Pin edge selectable rising or falling.
// RL17: Valid pin edge sets flag, may redirect.
// RL18: Entry copies core registers except two status bits.
// RL19: Return restores shadows; shadow writes change result.
// RL20: Shadows software accessible in bank thirty-one.
// RL21: Global bit seven, group bit six, reset zero.
// RL22: Change summary read-only, follows individual flags.
// RL23: Request is gated OR of flag and enable.
// RL24: One vector, no priority, software polls.
//
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "cis_defines.svh"
module cis_sequencer (
  // Clock and synchronous reset.
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // AXI4-Lite write channels.
  input wire logic i_axi_awvalid,
  output logic o_axi_awready,
  input wire logic [11:0] i_axi_awaddr,
  input wire logic i_axi_wvalid,
  output logic o_axi_wready,
  input wire logic [31:0] i_axi_wdata,
  input wire logic [3:0] i_axi_wstrb,
  output logic o_axi_bvalid,
  input wire logic i_axi_bready,
  output logic [1:0] o_axi_bresp,
  // AXI4-Lite read channels.
  input wire logic i_axi_arvalid,
  output logic o_axi_arready,
  input wire logic [11:0] i_axi_araddr,
  output logic o_axi_rvalid,
  input wire logic i_axi_rready,
  output logic [31:0] o_axi_rdata,
  output logic [1:0] o_axi_rresp,
  // Event sources.
  input wire logic i_ext_pin,
  input wire logic i_timer_overflow,
  input wire logic [7:0] i_change_events,
  input wire logic [7:0] i_periph_events,
  // Core side.
  input wire cis_pkg::cis_ctx_s i_core_ctx,
  input wire logic [14:0] i_core_pc,
  input wire logic i_return_from_handler,
  input wire logic i_sleep_active,
  output logic [1:0] o_phase,
  output logic o_irq_request,
  output logic o_flush,
  output logic o_push_pc,
  output logic [14:0] o_push_addr,
  output logic o_load_pc,
  output logic [14:0] o_pc_value,
  output logic o_pop_pc,
  output logic o_restore,
  output cis_pkg::cis_ctx_s o_restore_ctx,
  output logic o_wake
);
  // Control bits of the irq_control_reg.
  logic global_irq_enable;
  logic periph_group_enable;
  logic timer_irq_enable;
  logic ext_pin_irq_enable;
  logic change_irq_enable;
  logic timer_irq_flag;
  logic ext_pin_irq_flag;
  // Peripheral group enables and flags.
  logic [7:0] periph_enable_reg_1;
  logic [7:0] periph_flag_reg_1;
  // Individual change flags; the summary is derived from them.
  logic [7:0] change_flags;
  logic change_summary_flag;
  logic ext_edge_select;
  // External pin synchroniser, previous level and arming counter.
  logic ext_meta;
  logic ext_sync;
  logic ext_prev;
  logic [1:0] ext_arm;
  logic ext_edge_hit;
  // Sequencer state, quarter phase and wake guard.
  cis_pkg::cis_state_e state;
  logic [1:0] quarter;
  logic [1:0] wake_guard;
  logic pending;
  logic request;
  logic start_entry;
  logic push_go;
  logic vec_go;
  logic ret_go;
  // Held write address and data of the bus slave.
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [31:0] rd_word;
  logic [7:0] ctrl_word;

  // Tells whether an offset names a register; unaligned offsets do not.
  function automatic logic is_mapped(input logic [11:0] a);
    case (a)
      `CIS_OFS_CTRL, `CIS_OFS_PIE, `CIS_OFS_PIR, `CIS_OFS_CHG, `CIS_OFS_EDGE,
      `CIS_OFS_SH_ACC, `CIS_OFS_SH_STAT, `CIS_OFS_SH_BANK, `CIS_OFS_SH_IPTR,
      `CIS_OFS_SH_PCL: is_mapped = 1'h1;
      default: is_mapped = 1'h0;
    endcase
  endfunction

  // Write strobe of one register through byte lane zero.
  function automatic logic wr_hit(input logic [11:0] ofs);
    wr_hit = do_write && w_strb[0] && (aw_addr == ofs);
  endfunction

  // Quarter-phase counter; four system clocks form one instruction cycle.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      quarter <= `CIS_Q1;
    end else begin
      quarter <= quarter + `CIS_PHASE_STEP;
    end
  end

  // Write address channel; held until the response has been taken.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_axi_awready <= 1'h1;
      aw_addr <= 12'h000;
    end else if (i_axi_awvalid && o_axi_awready) begin
      o_axi_awready <= 1'h0;
      aw_addr <= i_axi_awaddr;
    end else if (o_axi_bvalid && i_axi_bready) begin
      o_axi_awready <= 1'h1;
    end
  end

  // Write data channel, taken independently of the address.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_axi_wready <= 1'h1;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (i_axi_wvalid && o_axi_wready) begin
      o_axi_wready <= 1'h0;
      w_data <= i_axi_wdata;
      w_strb <= i_axi_wstrb;
    end else if (o_axi_bvalid && i_axi_bready) begin
      o_axi_wready <= 1'h1;
    end
  end

  // The write is performed once, in the cycle both halves are held.
  assign do_write = !o_axi_awready && !o_axi_wready && !o_axi_bvalid;

  // Write response; an unmapped offset is answered with a slave error.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_axi_bvalid <= 1'h0;
      o_axi_bresp <= `CIS_RESP_OK;
    end else if (do_write) begin
      o_axi_bvalid <= 1'h1;
      o_axi_bresp <= is_mapped(aw_addr) ? `CIS_RESP_OK : `CIS_RESP_ERR;
    end else if (o_axi_bvalid && i_axi_bready) begin
      o_axi_bvalid <= 1'h0;
    end
  end

  // Packed view of the control register as software reads it.
  assign ctrl_word = {global_irq_enable, periph_group_enable, timer_irq_enable, ext_pin_irq_enable,
                      change_irq_enable, timer_irq_flag, ext_pin_irq_flag, change_summary_flag};

  // Read multiplexer; unused upper bits read as zero.
  always_comb begin
    rd_word = 32'h0000_0000;
    case (i_axi_araddr)
      `CIS_OFS_CTRL: rd_word[7:0] = ctrl_word;
      `CIS_OFS_PIE: rd_word[7:0] = periph_enable_reg_1;
      `CIS_OFS_PIR: rd_word[7:0] = periph_flag_reg_1;
      `CIS_OFS_CHG: rd_word[7:0] = change_flags;
      `CIS_OFS_EDGE: rd_word[0] = ext_edge_select;
      `CIS_OFS_SH_ACC: rd_word[7:0] = o_restore_ctx.acc; // [RL20]
      `CIS_OFS_SH_STAT: rd_word[7:0] = o_restore_ctx.status;
      `CIS_OFS_SH_BANK: rd_word[4:0] = o_restore_ctx.bank;
      `CIS_OFS_SH_IPTR: rd_word[15:0] = o_restore_ctx.ind_ptr;
      `CIS_OFS_SH_PCL: rd_word[6:0] = o_restore_ctx.pc_high_latch;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Read channel; reads have no side effects, so flags survive polling.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_axi_arready <= 1'h1;
      o_axi_rvalid <= 1'h0;
      o_axi_rdata <= 32'h0000_0000;
      o_axi_rresp <= `CIS_RESP_OK;
    end else if (i_axi_arvalid && o_axi_arready) begin
      o_axi_arready <= 1'h0;
      o_axi_rvalid <= 1'h1;
      o_axi_rdata <= rd_word;
      o_axi_rresp <= is_mapped(i_axi_araddr) ? `CIS_RESP_OK : `CIS_RESP_ERR;
    end else if (o_axi_rvalid && i_axi_rready) begin
      o_axi_rvalid <= 1'h0;
      o_axi_arready <= 1'h1;
    end
  end

  // External pin passes two flops before anything looks at it.
  always_ff @(posedge i_sys_clk) begin
    ext_meta <= i_ext_pin;
    ext_sync <= ext_meta;
    ext_prev <= ext_sync;
  end

  // Edges are ignored until the chain holds real pin levels, so reset cannot fake one.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      ext_arm <= 2'h0;
    end else if (ext_arm != `CIS_ARM_DONE) begin
      ext_arm <= ext_arm + 2'h1;
    end
  end

  // Edge polarity is chosen by the select bit.
  assign ext_edge_hit = (ext_arm == `CIS_ARM_DONE) &&
                        (ext_edge_select ? (ext_sync && !ext_prev) : (!ext_sync && ext_prev)); // [RL16]

  // Global enable: hardware entry and return outrank a software write in the same cycle.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      global_irq_enable <= 1'h0; // [RL1] [RL21]
    end else if (start_entry) begin
      global_irq_enable <= 1'h0; // [RL4]
    end else if (ret_go) begin
      global_irq_enable <= 1'h1; // [RL6]
    end else if (wr_hit(`CIS_OFS_CTRL)) begin
      global_irq_enable <= w_data[`CIS_B_GLOBAL_EN];
    end
  end

  // Enables of the control and peripheral enable registers, and edge select.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      periph_group_enable <= 1'h0; // [RL21]
      timer_irq_enable <= 1'h0;
      ext_pin_irq_enable <= 1'h0;
      change_irq_enable <= 1'h0;
      ext_edge_select <= 1'h0;
      periph_enable_reg_1 <= 8'h00;
    end else begin
      if (wr_hit(`CIS_OFS_CTRL)) begin
        periph_group_enable <= w_data[`CIS_B_GROUP_EN];
        timer_irq_enable <= w_data[`CIS_B_TIE];
        ext_pin_irq_enable <= w_data[`CIS_B_EIE];
        change_irq_enable <= w_data[`CIS_B_CIE];
      end
      if (wr_hit(`CIS_OFS_EDGE)) begin
        ext_edge_select <= w_data[0];
      end
      if (wr_hit(`CIS_OFS_PIE)) begin
        periph_enable_reg_1 <= w_data[7:0];
      end
    end
  end

  // Flags set on their events whatever the enables say; a set in the clearing cycle wins.
  // Hardware never clears them, so the handler must.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      timer_irq_flag <= 1'h0;
      ext_pin_irq_flag <= 1'h0;
      periph_flag_reg_1 <= 8'h00;
      change_flags <= 8'h00;
    end else begin
      timer_irq_flag <= (wr_hit(`CIS_OFS_CTRL) ? w_data[`CIS_B_TIF] : timer_irq_flag) | i_timer_overflow; // [RL3]
      ext_pin_irq_flag <= (wr_hit(`CIS_OFS_CTRL) ? w_data[`CIS_B_EIF] : ext_pin_irq_flag) | ext_edge_hit; // [RL17]
      periph_flag_reg_1 <= (wr_hit(`CIS_OFS_PIR) ? w_data[7:0] : periph_flag_reg_1) | i_periph_events; // [RL3] [RL8]
      change_flags <= (wr_hit(`CIS_OFS_CHG) ? w_data[7:0] : change_flags) | i_change_events;
    end
  end

  // Summary is not stored; it drops as soon as the last change flag is cleared.
  assign change_summary_flag = |change_flags; // [RL22]

  // Any enabled flag; a single shared vector and no priority among sources.
  assign pending = (timer_irq_enable && timer_irq_flag) || (ext_pin_irq_enable && ext_pin_irq_flag) ||
                   (change_irq_enable && change_summary_flag) ||
                   (periph_group_enable && |(periph_enable_reg_1 & periph_flag_reg_1)); // [RL2] [RL23] [RL24]
  assign request = global_irq_enable && pending; // [RL2] [RL23]

  // Sampling only at the first quarter; entry never waits for an instruction boundary.
  assign start_entry = (state == cis_pkg::ST_IDLE) && (quarter == `CIS_Q1) && request &&
                       (wake_guard == 2'h0) && !i_sleep_active; // [RL7] [RL9] [RL10] [RL11] [RL12]
  assign push_go = (state == cis_pkg::ST_FLUSH) && (quarter == `CIS_Q4);
  assign vec_go = (state == cis_pkg::ST_VECTOR) && (quarter == `CIS_Q4);
  assign ret_go = i_return_from_handler && (state == cis_pkg::ST_IDLE);

  // Entry sequencer: flush, push and save, then vector, one instruction cycle each.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state <= cis_pkg::ST_IDLE;
    end else begin
      case (state)
        cis_pkg::ST_IDLE: begin
          if (start_entry) begin
            state <= cis_pkg::ST_FLUSH; // [RL4]
          end
        end
        cis_pkg::ST_FLUSH: begin
          if (push_go) begin
            state <= cis_pkg::ST_PUSH;
          end
        end
        cis_pkg::ST_PUSH: begin
          if (quarter == `CIS_Q4) begin
            state <= cis_pkg::ST_VECTOR;
          end
        end
        cis_pkg::ST_VECTOR: begin
          if (vec_go) begin
            state <= cis_pkg::ST_IDLE;
          end
        end
        default: state <= cis_pkg::ST_IDLE;
      endcase
    end
  end

  // Core strobes of the entry and return sequences.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_flush <= 1'h0;
      o_push_pc <= 1'h0;
      o_push_addr <= `CIS_PC_RESET;
      o_load_pc <= 1'h0;
      o_pc_value <= `CIS_PC_RESET;
      o_pop_pc <= 1'h0;
      o_restore <= 1'h0;
      o_irq_request <= 1'h0;
      o_phase <= `CIS_Q1;
    end else begin
      o_flush <= start_entry; // [RL4]
      o_push_pc <= push_go;
      if (push_go) begin
        o_push_addr <= i_core_pc;
      end
      o_load_pc <= vec_go;
      if (vec_go) begin
        o_pc_value <= `CIS_VECTOR; // [RL4] [RL24]
      end
      o_pop_pc <= ret_go; // [RL6]
      o_restore <= ret_go; // [RL19]
      o_irq_request <= request;
      o_phase <= quarter;
    end
  end

  // Shadow copies; the entry save outranks a software write in the same cycle.
  // Timeout and power-down bits are not saved, so the core keeps its own on restore.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_restore_ctx <= '0;
    end else if (push_go) begin
      o_restore_ctx <= i_core_ctx; // [RL18]
      o_restore_ctx.status <= i_core_ctx.status & `CIS_STAT_SAVE_MASK; // [RL18]
    end else begin
      if (wr_hit(`CIS_OFS_SH_ACC)) begin
        o_restore_ctx.acc <= w_data[7:0]; // [RL19] [RL20]
      end
      if (wr_hit(`CIS_OFS_SH_STAT)) begin
        o_restore_ctx.status <= w_data[7:0] & `CIS_STAT_SAVE_MASK;
      end
      if (wr_hit(`CIS_OFS_SH_BANK)) begin
        o_restore_ctx.bank <= w_data[4:0];
      end
      if (wr_hit(`CIS_OFS_SH_IPTR)) begin
        o_restore_ctx.ind_ptr[7:0] <= w_data[7:0];
      end
      if (do_write && w_strb[1] && (aw_addr == `CIS_OFS_SH_IPTR)) begin
        o_restore_ctx.ind_ptr[15:8] <= w_data[15:8];
      end
      if (wr_hit(`CIS_OFS_SH_PCL)) begin
        o_restore_ctx.pc_high_latch <= w_data[6:0];
      end
    end
  end

  // Wake works from enables alone; the guard lets the instruction after sleep run first.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_wake <= 1'h0;
      wake_guard <= 2'h0;
    end else begin
      o_wake <= i_sleep_active && pending && (wake_guard == 2'h0); // [RL14]
      if (i_sleep_active && pending && (wake_guard == 2'h0)) begin
        wake_guard <= `CIS_GUARD_WAKE; // [RL15]
      end else if ((quarter == `CIS_Q1) && (wake_guard != 2'h0)) begin
        wake_guard <= wake_guard - 2'h1;
      end
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  sequence s_flush_step;
    o_flush && !global_irq_enable;
  endsequence
  sequence s_vector_step;
    o_load_pc && (o_pc_value == `CIS_VECTOR);
  endsequence

  property p_reset_disabled;
    $past(i_reset) |-> !global_irq_enable && (state == cis_pkg::ST_IDLE);
  endproperty
  a_reset_disabled: assert property (p_reset_disabled) else $error("enable set after reset"); // [RL1]
  property p_entry_enables;
    start_entry |-> global_irq_enable && pending;
  endproperty
  a_entry_enables: assert property (p_entry_enables) else $error("entry without enables"); // [RL2]
  property p_flag_set;
    i_timer_overflow |=> timer_irq_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("timer flag lost"); // [RL3]
  property p_entry_seq;
    start_entry |=> s_flush_step ##3 o_push_pc ##8 s_vector_step;
  endproperty
  a_entry_seq: assert property (p_entry_seq) else $error("entry sequence wrong"); // [RL4]
  property p_no_redirect;
    (state == cis_pkg::ST_IDLE) && !global_irq_enable |=> (state == cis_pkg::ST_IDLE);
  endproperty
  a_no_redirect: assert property (p_no_redirect) else $error("redirect with enable clear"); // [RL5]
  property p_return;
    ret_go |=> o_restore && o_pop_pc && global_irq_enable;
  endproperty
  a_return: assert property (p_return) else $error("return incomplete"); // [RL6]
  property p_sample_q1;
    (state == cis_pkg::ST_FLUSH) && $past(state == cis_pkg::ST_IDLE) |-> $past(quarter) == `CIS_Q1;
  endproperty
  a_sample_q1: assert property (p_sample_q1) else $error("sampled off first quarter"); // [RL12]
  property p_edge_flag;
    ext_edge_hit |=> ext_pin_irq_flag;
  endproperty
  a_edge_flag: assert property (p_edge_flag) else $error("pin edge flag lost"); // [RL17]
  property p_wake_guard;
    o_wake |-> (state == cis_pkg::ST_IDLE)[*5];
  endproperty
  a_wake_guard: assert property (p_wake_guard) else $error("vectored before next instruction"); // [RL15]
endmodule

// ===== verif/cis_core_model.sv
// Behavioural core model that supplies live context and program counter to the sequencer.
`timescale 1ns/1ps
module cis_core_model (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // Commands from the sequencer.
  input wire logic i_load_pc,
  input wire logic [14:0] i_pc_value,
  input wire logic i_restore,
  input wire cis_pkg::cis_ctx_s i_restore_ctx,
  // Live core state.
  output cis_pkg::cis_ctx_s o_ctx,
  output logic [14:0] o_pc
);
  // Live registers start from a non-zero pattern so that a missing copy shows up.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_ctx <= '{acc: 8'h3c, status: 8'hff, bank: 5'h1f, ind_ptr: 16'h1234, pc_high_latch: 7'h55};
    end else if (i_restore) begin
      // The core keeps its own timeout and powerdown bits across a return.
      o_ctx <= i_restore_ctx;
      o_ctx.status <= (i_restore_ctx.status & 8'he7) | (o_ctx.status & 8'h18);
    end
  end
  // The program counter stands still between vector loads so that the pushed address is predictable.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_pc <= 15'h0123;
    end else if (i_load_pc) begin
      o_pc <= i_pc_value;
    end
  end
endmodule

// ===== verif/core_interrupt_sequencer_tb_top.sv
// Self-checking bench of the interrupt sequencer driven through its register port.
`timescale 1ns/1ps
module core_interrupt_sequencer_tb_top;
  // Stimulus, all but the clock driven by non-blocking assignment after a rising edge.
  logic clk = 1'b0, rst = 1'b1;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b1, arv = 1'b0, rry = 1'b1;
  logic [11:0] awa = 12'h000, ara = 12'h000;
  logic [31:0] wd = 32'h0000_0000;
  logic pin = 1'b0, tmr = 1'b0, ret = 1'b0, slp = 1'b0;
  logic [7:0] per = 8'h00, chg = 8'h00;
  // Design outputs.
  logic awr, wr_rdy, bv, arr, rv, irq, fl, psh, ld, pop, rs, wk;
  logic [1:0] br, rr, ph, resp;
  logic [31:0] rd_data, rdv;
  logic [14:0] pa, pcv, cpc;
  cis_pkg::cis_ctx_s cctx, rctx;
  int num_errors = 0, n_compared = 0, cyc = 0, n;
  always #12.5 clk = ~clk;
  cis_sequencer u_cis_sequencer (.i_sys_clk(clk), .i_reset(rst), .i_axi_awvalid(awv), .o_axi_awready(awr),
    .i_axi_awaddr(awa), .i_axi_wvalid(wv), .o_axi_wready(wr_rdy), .i_axi_wdata(wd), .i_axi_wstrb(4'hf),
    .o_axi_bvalid(bv), .i_axi_bready(bry), .o_axi_bresp(br), .i_axi_arvalid(arv), .o_axi_arready(arr),
    .i_axi_araddr(ara), .o_axi_rvalid(rv), .i_axi_rready(rry), .o_axi_rdata(rd_data), .o_axi_rresp(rr),
    .i_ext_pin(pin), .i_timer_overflow(tmr), .i_change_events(chg), .i_periph_events(per),
    .i_core_ctx(cctx), .i_core_pc(cpc), .i_return_from_handler(ret), .i_sleep_active(slp), .o_phase(ph),
    .o_irq_request(irq), .o_flush(fl), .o_push_pc(psh), .o_push_addr(pa), .o_load_pc(ld), .o_pc_value(pcv),
    .o_pop_pc(pop), .o_restore(rs), .o_restore_ctx(rctx), .o_wake(wk));
  cis_core_model u_cis_core_model (.i_sys_clk(clk), .i_reset(rst), .i_load_pc(ld), .i_pc_value(pcv),
    .i_restore(rs), .i_restore_ctx(rctx), .o_ctx(cctx), .o_pc(cpc));
  // Every comparison goes through here so that the counts stay honest.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Write cycle: each channel is released at the edge that takes it; bready stays high throughout.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic got;
    got = 1'b0;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    while (awv || wv || !got) begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_rdy) wv <= 1'b0;
      if (bv) begin
        resp = br;
        got = 1'b1;
      end
    end
  endtask
  // Read cycle: data and response are taken at the edge where rvalid is seen; rready stays high.
  task automatic rd(input logic [11:0] a);
    logic got;
    got = 1'b0;
    ara <= a;
    arv <= 1'b1;
    while (arv || !got) begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
      if (rv) begin
        rdv = rd_data;
        resp = rr;
        got = 1'b1;
      end
    end
  endtask
  // Flags must collect events even with every enable off.
  task automatic t_flag_only();
    tmr <= 1'b1;
    @(posedge clk);
    tmr <= 1'b0;
    repeat (8) @(posedge clk);
    check(32'(irq), 32'h0);
    rd(12'h000);
    check(rdv, 32'h0000_0004);
    wr(12'h000, 32'h0000_0000);
    $display("test flag_only done");
  endtask
  // Entry: latency, vector, pushed address, cleared global enable and saved context.
  task automatic t_entry();
    wr(12'h000, 32'h0000_00a0);
    tmr <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      tmr <= 1'b0;
      n++;
    end while (!ld && n < 40);
    check(32'(n >= 12 && n <= 20), 32'h1);
    check(32'(pcv), 32'h0000_0004);
    check(32'(pa), 32'h0000_0123);
    rd(12'h000);
    check(rdv, 32'h0000_0024);
    rd(12'hf80);
    check(rdv, 32'h0000_003c);
    rd(12'hf84);
    check(rdv, 32'h0000_00e7);
    $display("test entry done");
  endtask
  // Return restores the edited shadow and brings global enable back without re-entry.
  task automatic t_return();
    wr(12'hf80, 32'h0000_005a);
    wr(12'h000, 32'h0000_0020);
    ret <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      ret <= 1'b0;
      n++;
    end while (!rs && n < 6);
    check(32'(pop), 32'h1);
    check(32'(rctx.acc), 32'h0000_005a);
    rd(12'h000);
    check(rdv, 32'h0000_00a0);
    check(32'(cctx.acc), 32'h0000_005a);
    repeat (8) @(posedge clk);
    check(32'(irq), 32'h0);
    $display("test return done");
  endtask
  // A peripheral source waits for the group enable, then enters.
  task automatic t_group();
    wr(12'h004, 32'h0000_0001);
    per <= 8'h01;
    @(posedge clk);
    per <= 8'h00;
    repeat (8) @(posedge clk);
    check(32'(irq), 32'h0);
    wr(12'h000, 32'h0000_00e0);
    n = 0;
    while (!fl && n < 12) begin
      @(posedge clk);
      n++;
    end
    check(32'(fl), 32'h1);
    check(32'(ph), 32'h0);
    repeat (3) @(posedge clk);
    check(32'(psh), 32'h1);
    $display("test group done");
  endtask
  // Rising edge on the pin sets its flag; unmapped offsets are refused.
  task automatic t_pin_unmapped();
    wr(12'h010, 32'h0000_0001);
    pin <= 1'b1;
    repeat (8) @(posedge clk);
    rd(12'h000);
    check(rdv, 32'h0000_0062);
    wr(12'h020, 32'h0000_0001);
    check(32'(resp), 32'h2);
    rd(12'h020);
    check(32'(resp), 32'h2);
    $display("test pin_unmapped done");
  endtask
  // Wake from sleep: without global enable the event waits; with it the vector waits past the next instruction.
  task automatic t_sleep_wake();
    wr(12'h008, 32'h0000_0000);
    wr(12'h000, 32'h0000_0008);
    slp <= 1'b1;
    chg <= 8'h01;
    @(posedge clk);
    chg <= 8'h00;
    n = 0;
    while (!wk && n < 8) begin
      @(posedge clk);
      n++;
    end
    check(32'(wk), 32'h1);
    slp <= 1'b0;
    rd(12'h000);
    check(rdv, 32'h0000_0009);
    wr(12'h000, 32'h0000_0088);
    n = 0;
    while (!fl && n < 24) begin
      @(posedge clk);
      n++;
    end
    check(32'(fl), 32'h1);
    wr(12'h00c, 32'h0000_0000);
    rd(12'h000);
    check(rdv, 32'h0000_0008);
    repeat (12) @(posedge clk);
    ret <= 1'b1;
    @(posedge clk);
    ret <= 1'b0;
    slp <= 1'b1;
    chg <= 8'h01;
    @(posedge clk);
    chg <= 8'h00;
    n = 0;
    while (!wk && n < 8) begin
      @(posedge clk);
      n++;
    end
    check(32'(wk), 32'h1);
    slp <= 1'b0;
    n = 0;
    while (!fl && n < 24) begin
      @(posedge clk);
      n++;
    end
    check(32'(fl && n >= 5), 32'h1);
    $display("test sleep_wake done");
  endtask
  // Closing report, reached from the main sequence or the timeout.
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // A hang is cut short well past the expected run length.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      report_and_stop();
    end
  end
  // Main sequence.
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(12'h000);
    check(rdv, 32'h0000_0000);
    t_flag_only();
    t_entry();
    t_return();
    t_group();
    t_pin_unmapped();
    t_sleep_wake();
    report_and_stop();
  end
endmodule
